// >>> pkg/acr_defines.vh
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH
// Register addresses on the serial control port.
`define ACR_ADDR_W          15
`define ACR_ADR_CLK_CTRL0   15'h0029
`define ACR_ADR_NOISE_CTRL  15'h002b
`define ACR_ADR_SREF_POS0   15'h002c
`define ACR_ADR_SREF_POS1   15'h002d
`define ACR_ADR_SREF_POS2   15'h002e
`define ACR_ADR_FS_LO       15'h0030
`define ACR_ADR_FS_HI       15'h0031
`define ACR_ADR_MODE_A      15'h0037
`define ACR_ADR_TSTAMP      15'h003b
// Reset values.
`define ACR_RST_CLK_CTRL0   8'h80
`define ACR_RST_NOISE_CTRL  8'h10
`define ACR_RST_FS          16'ha000
`define ACR_RST_MODE        8'h4b
`define ACR_RST_TSTAMP      8'h00
// Field positions.
`define ACR_BIT_CLK_SUPPR   0
`define ACR_BIT_QUIET_SUPPR 2
`define ACR_BIT_TS_RECV     0
`define ACR_BIT_TS_PECL     1
// Operating mode codes.
`define ACR_MODE_LOW_POWER  8'h46
`define ACR_MODE_HIGH_PERF  8'h4b
`endif

// >>> logic/acr_sync3.v
`timescale 1ns/1ns
// Three-stage pin synchroniser; output moves once stages two and three agree.
module acr_sync3 (
	// Clock and reset
	input  wire REF_CLK,
	input  wire RSTN,
	// Pin and filtered level
	input  wire PIN,
	output reg  LEVEL
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			LEVEL <= 1'b0;
		end else begin
			s1_q <= PIN;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				LEVEL <= s3_q;
			end
		end
	end
endmodule // acr_sync3

// >>> logic/acr_regs.v
`timescale 1ns/1ns
`include "acr_defines.vh"
// Operation
// [R1] Software writes reserved fields with their reset value.
// [R2] Noise control bit 2 enables quiet analog rail suppression; resets off.
// [R3] Noise control bit 0 enables clock rail suppression; resets off.
// [R4] Read-only 24-bit edge location word reports the captured alignment edge.
// [R5] Software reads edge location to pick the delay choice.
// [R6] Four-bit delay choice in clock control bits 3:0 selects capture delay.
// [R7] Sixteen-bit full-scale code sets range for all channels; resets 0xa000.
// [R8] Software keeps full-scale code at or above 0x2000.
// [R9] Mode code 0x46 low power, 0x4b high performance; others reserved.
// [R10] Software programs all four mode registers consistently.
// [R11] Calibration and serial link disabled before changing mode code.
// [R12] Software recalibrates after any mode change.
// [R13] Timestamp bit 1 selects PECL termination, no self-bias; resets off.
// [R14] Timestamp bit 0 enables the timestamp receiver; resets off.
// [R15] Read-write fields read back last write; status writes are ignored.
module acr_regs (
	// Clock and reset
	input  wire        REF_CLK,
	input  wire        RSTN,
	// Serial control port, already deserialised by the port engine
	input  wire        WR_STB,
	input  wire        RD_STB,
	input  wire [14:0] ADDR,
	input  wire [7:0]  WDATA,
	output reg  [7:0]  RDATA,
	output reg         RVALID,
	// Edge location from the alignment detector, another clock domain
	input  wire [23:0] EDGE_LOCATION_IN,
	// Analog controls
	output wire [3:0]  SYSREF_DELAY_CHOICE,
	output wire        QUIET_RAIL_SUPPRESS_ENABLE,
	output wire        CLOCK_RAIL_SUPPRESS_ENABLE,
	output wire [15:0] FULL_SCALE_CODE,
	output wire [7:0]  OPERATING_MODE_CODE,
	output wire        LOW_POWER_ACTIVE,
	output wire        MODE_CODE_RESERVED,
	output wire        TIMESTAMP_PECL_TERMINATION,
	output wire        TIMESTAMP_RECEIVER_ENABLE
);
	reg  [7:0]  clk_ctrl0_q;
	reg  [7:0]  clk_ctrl0_d;
	reg  [7:0]  noise_q;
	reg  [7:0]  noise_d;
	reg  [15:0] fs_q;
	reg  [15:0] fs_d;
	reg  [7:0]  mode_q;
	reg  [7:0]  mode_d;
	reg  [7:0]  tstamp_q;
	reg  [7:0]  tstamp_d;
	reg         low_power_q;
	reg         low_power_d;
	reg         reserved_q;
	reg         reserved_d;
	wire [23:0] edge_sync;
	reg  [7:0]  rd_d;
	reg  [7:0]  rdata_d;
	reg         rvalid_d;
	wire        wr_clk_ctrl0;
	wire        wr_noise;
	wire        wr_fs_lo;
	wire        wr_fs_hi;
	wire        wr_mode;
	wire        wr_tstamp;

	// Each status bit is filtered separately; the detector only updates it
	// while idle, so a torn word is not a practical concern.
	genvar gi;
	generate
		for (gi = 0; gi < 24; gi = gi + 1) begin : g_sync
			acr_sync3 u_sync (
				.REF_CLK (REF_CLK),
				.RSTN    (RSTN),
				.PIN     (EDGE_LOCATION_IN[gi]),
				.LEVEL   (edge_sync[gi])
			);
		end
	endgenerate

	// The status addresses have no write decode, so writes there are lost.
	assign wr_clk_ctrl0 = WR_STB && (ADDR == `ACR_ADR_CLK_CTRL0);
	assign wr_noise     = WR_STB && (ADDR == `ACR_ADR_NOISE_CTRL);
	assign wr_fs_lo     = WR_STB && (ADDR == `ACR_ADR_FS_LO);
	assign wr_fs_hi     = WR_STB && (ADDR == `ACR_ADR_FS_HI);
	assign wr_mode      = WR_STB && (ADDR == `ACR_ADR_MODE_A);
	assign wr_tstamp    = WR_STB && (ADDR == `ACR_ADR_TSTAMP); // see [R15]

	// Reserved bits are stored as written; software keeps them at reset value.
	always @* begin
		clk_ctrl0_d = clk_ctrl0_q;
		if (wr_clk_ctrl0) begin
			clk_ctrl0_d = WDATA; // see [R6]
		end
	end

	always @* begin
		noise_d = noise_q;
		if (wr_noise) begin
			noise_d = WDATA; // see [R2] see [R3]
		end
	end

	// Each byte of the full-scale code updates on its own.
	always @* begin
		fs_d = fs_q;
		if (wr_fs_lo) begin
			fs_d[7:0] = WDATA; // see [R7]
		end
		if (wr_fs_hi) begin
			fs_d[15:8] = WDATA; // see [R7]
		end
	end

	always @* begin
		mode_d = mode_q;
		if (wr_mode) begin
			mode_d = WDATA; // see [R9]
		end
	end

	always @* begin
		tstamp_d = tstamp_q;
		if (wr_tstamp) begin
			tstamp_d = WDATA; // see [R13] see [R14]
		end
	end

	// Decodes are taken from the next code, so they switch on the same edge
	// as the code itself. Reserved codes keep high performance behaviour.
	always @* begin
		low_power_d = (mode_d == `ACR_MODE_LOW_POWER); // see [R9]
		reserved_d  = (mode_d != `ACR_MODE_LOW_POWER) &&
			(mode_d != `ACR_MODE_HIGH_PERF); // see [R9]
	end

	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			clk_ctrl0_q <= `ACR_RST_CLK_CTRL0;
			noise_q     <= `ACR_RST_NOISE_CTRL;
			fs_q        <= `ACR_RST_FS;
			mode_q      <= `ACR_RST_MODE;
			tstamp_q    <= `ACR_RST_TSTAMP;
			low_power_q <= 1'b0;
			reserved_q  <= 1'b0;
		end else begin
			clk_ctrl0_q <= clk_ctrl0_d;
			noise_q     <= noise_d;
			fs_q        <= fs_d;
			mode_q      <= mode_d;
			tstamp_q    <= tstamp_d;
			low_power_q <= low_power_d;
			reserved_q  <= reserved_d;
		end
	end

	always @* begin
		case (ADDR)
		`ACR_ADR_CLK_CTRL0:  rd_d = clk_ctrl0_q; // see [R15]
		`ACR_ADR_NOISE_CTRL: rd_d = noise_q;
		`ACR_ADR_SREF_POS0:  rd_d = edge_sync[7:0]; // see [R4]
		`ACR_ADR_SREF_POS1:  rd_d = edge_sync[15:8]; // see [R4]
		`ACR_ADR_SREF_POS2:  rd_d = edge_sync[23:16]; // see [R4]
		`ACR_ADR_FS_LO:      rd_d = fs_q[7:0];
		`ACR_ADR_FS_HI:      rd_d = fs_q[15:8];
		`ACR_ADR_MODE_A:     rd_d = mode_q;
		`ACR_ADR_TSTAMP:     rd_d = tstamp_q;
		default:             rd_d = 8'h00;
		endcase
	end

	// Read data holds until the next read so a slow port engine can take it.
	always @* begin
		rvalid_d = RD_STB;
		rdata_d  = RDATA;
		if (RD_STB) begin
			rdata_d = rd_d;
		end
	end

	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			RDATA  <= 8'h00;
			RVALID <= 1'b0;
		end else begin
			RDATA  <= rdata_d;
			RVALID <= rvalid_d;
		end
	end

	assign SYSREF_DELAY_CHOICE        = clk_ctrl0_q[3:0]; // see [R6]
	assign QUIET_RAIL_SUPPRESS_ENABLE = noise_q[`ACR_BIT_QUIET_SUPPR]; // see [R2]
	assign CLOCK_RAIL_SUPPRESS_ENABLE = noise_q[`ACR_BIT_CLK_SUPPR]; // see [R3]
	assign FULL_SCALE_CODE            = fs_q; // see [R7]
	assign OPERATING_MODE_CODE        = mode_q;
	assign LOW_POWER_ACTIVE           = low_power_q; // see [R9]
	assign MODE_CODE_RESERVED         = reserved_q; // see [R9]
	assign TIMESTAMP_PECL_TERMINATION = tstamp_q[`ACR_BIT_TS_PECL]; // see [R13]
	assign TIMESTAMP_RECEIVER_ENABLE  = tstamp_q[`ACR_BIT_TS_RECV]; // see [R14]
endmodule // acr_regs

// >>> bench/acr_edge_src.sv
`timescale 1ns/1ns
// Edge detector stand-in; its output is in another domain from the bank.
module acr_edge_src (
	// Bench clock
	input  wire        clk,
	// Location chosen by the bench and the word seen by the bank
	input  wire [23:0] loc,
	output reg  [23:0] edge_q
);
	always @(negedge clk) begin
		edge_q <= loc;
	end
endmodule // acr_edge_src

// >>> bench/acr_regs_sva.sv
`timescale 1ns/1ns
module acr_regs_sva (
	// Clock and reset
	input wire        REF_CLK,
	input wire        RSTN,
	// Register port
	input wire        WR_STB,
	input wire        RD_STB,
	input wire [14:0] ADDR,
	input wire [7:0]  WDATA,
	input wire [7:0]  RDATA,
	input wire        RVALID,
	// Controls
	input wire [15:0] FULL_SCALE_CODE,
	input wire [7:0]  OPERATING_MODE_CODE,
	input wire        LOW_POWER_ACTIVE,
	input wire        QUIET_RAIL_SUPPRESS_ENABLE,
	input wire        CLOCK_RAIL_SUPPRESS_ENABLE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	property p_rv;
		RD_STB |=> RVALID;
	endproperty
	a_rv: assert property (p_rv) else $error("read answer late");
	property p_rv0;
		!RD_STB |=> !RVALID;
	endproperty
	a_rv0: assert property (p_rv0) else $error("stray read answer");
	property p_qr;
		WR_STB && ADDR == 15'h002b |=>
			QUIET_RAIL_SUPPRESS_ENABLE == $past(WDATA[2]);
	endproperty
	a_qr: assert property (p_qr) else $error("quiet rail bit");
	property p_cr;
		WR_STB && ADDR == 15'h002b |=>
			CLOCK_RAIL_SUPPRESS_ENABLE == $past(WDATA[0]);
	endproperty
	a_cr: assert property (p_cr) else $error("clock rail bit");
	property p_fs;
		WR_STB && ADDR == 15'h0031 |=> FULL_SCALE_CODE[15:8] == $past(WDATA);
	endproperty
	a_fs: assert property (p_fs) else $error("range high byte");
	property p_lp;
		LOW_POWER_ACTIVE == (OPERATING_MODE_CODE == 8'h46);
	endproperty
	a_lp: assert property (p_lp) else $error("low power decode");
	property p_md;
		RD_STB && !WR_STB && ADDR == 15'h0037 |=>
			RDATA == OPERATING_MODE_CODE;
	endproperty
	a_md: assert property (p_md) else $error("mode readback");
	c_wr: cover property (WR_STB && ADDR == 15'h0030);
	c_rd: cover property (RVALID && RDATA != 8'h00);
	c_lp: cover property ($rose(LOW_POWER_ACTIVE));
endmodule // acr_regs_sva
bind acr_regs acr_regs_sva acr_regs_sva_inst (.*);

// >>> bench/acr_regs_tb.sv
`timescale 1ns/1ns
`include "acr_defines.vh"
module acr_regs_tb;
	reg         clk = 1'b0;
	reg         rstn = 1'b0;
	reg         ws = 1'b0;
	reg         rs = 1'b0;
	reg  [14:0] a = 15'h0000;
	reg  [7:0]  wd = 8'h00;
	reg  [7:0]  m [0:63];
	reg  [14:0] l [0:9];
	reg  [23:0] loc = 24'h000000;
	reg  [14:0] pick;
	reg  [33:0] exp_ctrl;
	wire [7:0]  rdat;
	wire [7:0]  md;
	wire        rv, lp, res, qr, cr, tp, tr;
	wire [3:0]  dly;
	wire [15:0] fs;
	wire [23:0] edg;
	wire [33:0] got_ctrl = {dly, qr, cr, fs, md, lp, res, tp, tr};
	integer     error_cnt = 0;
	integer     tests_run = 0;
	integer     i;
	always #5 clk = ~clk;
	acr_edge_src acr_edge_src_inst (.clk(clk), .loc(loc), .edge_q(edg));
	acr_regs acr_regs_inst (
		.REF_CLK(clk), .RSTN(rstn), .WR_STB(ws), .RD_STB(rs),
		.ADDR(a), .WDATA(wd), .RDATA(rdat), .RVALID(rv),
		.EDGE_LOCATION_IN(edg), .SYSREF_DELAY_CHOICE(dly),
		.QUIET_RAIL_SUPPRESS_ENABLE(qr), .CLOCK_RAIL_SUPPRESS_ENABLE(cr),
		.FULL_SCALE_CODE(fs), .OPERATING_MODE_CODE(md),
		.LOW_POWER_ACTIVE(lp), .MODE_CODE_RESERVED(res),
		.TIMESTAMP_PECL_TERMINATION(tp), .TIMESTAMP_RECEIVER_ENABLE(tr));
	task chk_ctrl(input [33:0] e, input [33:0] g); begin
		tests_run = tests_run + 1;
		if (e !== g) begin
			error_cnt = error_cnt + 1;
			$display("ERROR controls exp %h got %h", e, g);
		end
	end endtask
	task chk_rd(input [14:0] ad, input [8:0] e, input [8:0] g); begin
		tests_run = tests_run + 1;
		if (e !== g) begin
			error_cnt = error_cnt + 1;
			$display("ERROR read %h exp %h got %h", ad, e, g);
		end
	end endtask
	// Host software: reserved fields keep their reset value, codes stay legal.
	function [7:0] legal(input [14:0] ad, input [7:0] d); begin
		case (ad)
		`ACR_ADR_CLK_CTRL0:  legal = {1'b1, d[6:0]};
		`ACR_ADR_NOISE_CTRL: legal = (d & 8'h05) | 8'h10;
		`ACR_ADR_FS_HI:      legal = (d < 8'h20) ? (d | 8'h20) : d;
		`ACR_ADR_MODE_A:     legal = d[0] ? `ACR_MODE_LOW_POWER :
			`ACR_MODE_HIGH_PERF;
		`ACR_ADR_TSTAMP:     legal = d & 8'h03;
		default:             legal = d;
		endcase
	end endfunction
	task wr(input [14:0] ad, input [7:0] d); begin
		@(negedge clk);
		ws = 1'b1;
		a = ad;
		wd = d;
		@(negedge clk);
		ws = 1'b0;
		if (ad < 15'd64 && (ad < 15'h2c || ad > 15'h2e)) m[ad] = d;
		exp_ctrl = {m[41][3:0], m[43][`ACR_BIT_QUIET_SUPPR],
			m[43][`ACR_BIT_CLK_SUPPR], m[49], m[48], m[55],
			m[55] == `ACR_MODE_LOW_POWER,
			m[55] != `ACR_MODE_LOW_POWER && m[55] != `ACR_MODE_HIGH_PERF,
			m[59][`ACR_BIT_TS_PECL], m[59][`ACR_BIT_TS_RECV]};
		chk_ctrl(exp_ctrl, got_ctrl);
	end endtask
	task rd(input [14:0] ad); begin
		@(negedge clk);
		rs = 1'b1;
		a = ad;
		@(negedge clk);
		rs = 1'b0;
		chk_rd(ad, {1'b1, ad < 15'd64 ? m[ad] : 8'h00}, {rv, rdat});
	end endtask
	task report_and_stop; begin
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	end endtask
	initial begin #100000; error_cnt = error_cnt + 1; report_and_stop; end
	initial begin
		for (i = 0; i < 64; i = i + 1) m[i] = 8'h00;
		m[41] = 8'h80; m[43] = 8'h10; m[49] = 8'ha0; m[55] = 8'h4b;
		l[0] = 15'h29; l[1] = 15'h2b; l[2] = 15'h2c; l[3] = 15'h2d;
		l[4] = 15'h2e; l[5] = 15'h30; l[6] = 15'h31; l[7] = 15'h37;
		l[8] = 15'h3b; l[9] = 15'h7f;
		i = $urandom(56004);
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		for (i = 0; i < 10; i = i + 1) rd(l[i]);
		for (i = 0; i < 60; i = i + 1) begin
			pick = l[$urandom % 10];
			wr(pick, legal(pick, $urandom));
		end
		// Calibration and serial link enables live outside this slice and
		// stay off; companion mode registers and recalibration do too.
		wr(`ACR_ADR_MODE_A, `ACR_MODE_LOW_POWER);
		wr(`ACR_ADR_MODE_A, `ACR_MODE_HIGH_PERF);
		loc = $urandom;
		repeat (8) @(negedge clk);
		m[44] = loc[7:0];
		m[45] = loc[15:8];
		m[46] = loc[23:16];
		for (i = 0; i < 10; i = i + 1) rd(l[i]);
		wr(`ACR_ADR_CLK_CTRL0, {4'h8, m[44][3:0]});
		rd(`ACR_ADR_CLK_CTRL0);
		report_and_stop;
	end
endmodule // acr_regs_tb
